// ===== dv/program_sequencer_tb_top.sv
// self-checking bench for the program sequencer
// assumes the memory model on the fetch side, wake pin driven here
`timescale 1ns/1ps
module program_sequencer_tb_top;
  import psq_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  psq_op_type op_i = PSQ_OP_NEXT;
  logic op_valid_i = 1'b0;
  logic skip_met_i = 1'b0;
  logic wake_i = 1'b0;
  logic [14:0] push;
  logic [5:0] irq_i = 6'h00;
  logic [15:0] data;
  logic [15:0] insn;
  logic [14:0] addr;
  logic [3:0] phase;
  logic fetch;
  logic valid;
  logic ack;
  logic run;
  int n_errors = 0;
  int total_checks = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  psq_sequencer dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wake_i(wake_i), .op_i(op_i),
    .op_valid_i(op_valid_i), .skip_met_i(skip_met_i), .target_i(13'h0ABC), .bank_select_low_bit_i(1'b0),
    .bank_select_high_bit_i(1'b1), .counter_low_byte_i(8'h5A), .stack_top_i(15'h7FFF), .irq_i(irq_i),
    .prog_data_i(data), .phase_o(phase), .prog_addr_o(addr), .fetch_o(fetch), .insn_o(insn),
    .insn_valid_o(valid), .irq_ack_o(ack), .push_pc_o(push), .running_o(run));
  psq_prog_mem mem_u (.addr_i(addr), .data_o(data));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // one instruction cycle; called just after a falling edge
  task automatic cyc(input psq_op_type op, input logic [5:0] irq, output logic [1:0] f, output int n);
    op_i = op;
    op_valid_i = op != PSQ_OP_NEXT;
    irq_i = irq;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    while (fetch !== 1'b1 && n < 8);
    f = {ack, valid};
    @(negedge sys_clk_i);
  endtask
  task automatic t_reset;
    repeat (3) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (1023) @(posedge sys_clk_i);
    #1;
    chk("running", 16'h0, 16'(run));
    chk("phase", 16'h1, 16'(phase));
    chk("addr", 16'h0, 16'(addr));
    @(posedge sys_clk_i);
    #1;
    chk("running", 16'h1, 16'(run));
    @(negedge sys_clk_i);
  endtask
  task automatic t_seq;
    logic [1:0] f;
    int n;
    cyc(PSQ_OP_NEXT, 6'h00, f, n);
    cyc(PSQ_OP_NEXT, 6'h00, f, n);
    chk("spacing", 16'h4, 16'(n));
    chk("addr", 16'h2, 16'(addr));
    chk("insn", 16'h8001, insn);
  endtask
  task automatic t_branch;
    logic [1:0] f;
    int n;
    cyc(PSQ_OP_JUMP, 6'h00, f, n);
    chk("jump", 16'h4ABC, 16'(addr));
    chk("dummy", 16'h0, 16'(f[0]));
    cyc(PSQ_OP_NEXT, 6'h00, f, n);
    chk("target valid", 16'h1, 16'(f[0]));
    chk("target insn", 16'hCABC, insn);
    cyc(PSQ_OP_LOW, 6'h00, f, n);
    chk("low", 16'h4A5A, 16'(addr));
    cyc(PSQ_OP_NEXT, 6'h00, f, n);
    cyc(PSQ_OP_CALL, 6'h00, f, n);
    chk("call", 16'h4ABC, 16'(addr));
    chk("push", 16'h4A5B, 16'(push));
    cyc(PSQ_OP_NEXT, 6'h00, f, n);
    cyc(PSQ_OP_RET, 6'h00, f, n);
    chk("ret", 16'h7FFF, 16'(addr));
    cyc(PSQ_OP_NEXT, 6'h00, f, n);
  endtask
  task automatic t_skip;
    logic [1:0] f;
    int n;
    for (int k = 1; k >= 0; k--)
    begin
      skip_met_i = k[0];
      cyc(PSQ_OP_SKIP, 6'h00, f, n);
      chk("skip slot", 16'(1 - k), 16'(f[0]));
      cyc(PSQ_OP_NEXT, 6'h00, f, n);
      chk("after skip", 16'h1, 16'(f[0]));
    end
  endtask
  task automatic t_irq;
    logic [1:0] f;
    int n;
    for (int k = 0; k < 6; k++)
    begin
      cyc(PSQ_OP_NEXT, 6'(1 << k), f, n);
      chk("ack", 16'h1, 16'(f[1]));
      chk("irq slot", 16'h0, 16'(f[0]));
      chk("vector", 16'(4 * (k + 1)), 16'(addr));
      cyc(PSQ_OP_NEXT, 6'h00, f, n);
    end
  endtask
  task automatic t_wake;
    wake_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("running", 16'h0, 16'(run));
    chk("phase", 16'h1, 16'(phase));
    repeat (1023) @(posedge sys_clk_i);
    #1;
    chk("running", 16'h0, 16'(run));
    @(posedge sys_clk_i);
    #1;
    chk("running", 16'h1, 16'(run));
    @(negedge sys_clk_i);
    wake_i = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_seq();
    t_branch();
    t_skip();
    t_irq();
    t_wake();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule

// ===== dv/psq_chk_properties.sv
// port assertions for the program sequencer
// assumes binding onto the sequencer top, one clock
`timescale 1ns/1ps
module psq_chk
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire psq_pkg::psq_op_type op_i,
  input wire logic op_valid_i,
  input wire logic [5:0] irq_i,
  input wire logic [7:0] counter_low_byte_i,
  input wire logic [3:0] phase_o,
  input wire logic [14:0] prog_addr_o,
  input wire logic fetch_o,
  input wire logic insn_valid_o,
  input wire logic irq_ack_o,
  input wire logic running_o
);
  import psq_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_ONE_HOT: assert property (running_o |-> $onehot(phase_o)) else $error("phase not one-hot");
  AST_FOUR: assert property (fetch_o |=> !fetch_o [*3] ##1 (fetch_o || !running_o))
    else $error("cycle length wrong");
  AST_STEP: assert property (fetch_o && !$past(op_valid_i) && $past(irq_i) == 6'h00
    |-> prog_addr_o == $past(prog_addr_o) + PC_STEP) else $error("no step");
  AST_HOLD_ADDR: assert property (!fetch_o && $past(running_o) |-> $stable(prog_addr_o))
    else $error("addr moved");
  AST_LOW: assert property (fetch_o && !insn_valid_o && $past(op_valid_i) && $past(op_i) == PSQ_OP_LOW
    && $past(irq_i) == 6'h00 |-> prog_addr_o == {7'($past(prog_addr_o) >> 8), $past(counter_low_byte_i)})
    else $error("low byte load wrong");
  AST_DUMMY: assert property (fetch_o && !insn_valid_o && running_o && $past(op_valid_i)
    && $past(op_i) == PSQ_OP_JUMP && $past(irq_i) == 6'h00 |=> ##3 fetch_o && (insn_valid_o || irq_ack_o))
    else $error("no dummy cycle");
  AST_VEC0: assert property (irq_ack_o && $past(irq_i) == 6'h01 |-> prog_addr_o == VEC_EXT0)
    else $error("vector wrong");
  AST_RESET: assert property ($rose(nrst_i) |-> prog_addr_o == VEC_RESET && !running_o)
    else $error("reset state wrong");
endmodule
bind psq_sequencer psq_chk chk_u (.*);

// ===== dv/psq_prog_mem.sv
// program memory model: each word is its address with bit 15 set
// assumes a combinational read, settled by phase 3
`timescale 1ns/1ps
module psq_prog_mem
(
  input wire logic [psq_pkg::PC_W-1:0] addr_i,
  output logic [psq_pkg::WORD_W-1:0] data_o
);
  assign data_o = {1'b1, addr_i};
endmodule

// ===== inc/psq_pkg.sv
// constants and types for the program sequencer
// assumes a 50 MHz system clock and a 15-bit program space
package psq_pkg;
  localparam int PC_W = 15;
  localparam int WORD_W = 16;
  localparam int INSN_ADDR_W = 13;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [PC_W-1:0] VEC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] VEC_EXT0 = 15'h0004;
  localparam logic [PC_W-1:0] VEC_EXT1 = 15'h0008;
  localparam logic [PC_W-1:0] VEC_TMR0 = 15'h000C;
  localparam logic [PC_W-1:0] VEC_TMR1 = 15'h0010;
  localparam logic [PC_W-1:0] VEC_UART = 15'h0014;
  localparam logic [PC_W-1:0] VEC_MULTI = 15'h0018;
  localparam int NUM_IRQ = 6;
  // start-up hold in system clock periods
  localparam int STARTUP_PERIODS = 1024;
  localparam int STARTUP_W = 11;
  localparam logic [STARTUP_W-1:0] STARTUP_HOLD_COUNT = STARTUP_W'(STARTUP_PERIODS);
  localparam logic [STARTUP_W-1:0] STARTUP_ZERO = 11'h000;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [3:0] PHASE_ONE_HOT_ZERO = 4'h1;
  typedef enum logic [2:0]
  {
    PSQ_OP_NEXT = 3'b000,
    PSQ_OP_SKIP = 3'b001,
    PSQ_OP_JUMP = 3'b010,
    PSQ_OP_CALL = 3'b011,
    PSQ_OP_RET = 3'b100,
    PSQ_OP_LOW = 3'b101
  } psq_op_type;
  typedef enum logic [1:0]
  {
    PSQ_ST_HOLD = 2'b00,
    PSQ_ST_RUN = 2'b01,
    PSQ_ST_FLUSH = 2'b10
  } psq_state_type;
endpackage

// ===== rtl/psq_sequencer.sv
// program counter and four-phase instruction sequencer
// assumes program memory answers within one instruction cycle and the
// core presents op and operands during the last phase of a cycle
//
// What this block does
// - four non-overlapping phase clocks sequence cycles
// - each instruction cycle is four clocks
// - fetch next while current one executes
// - counter-changing instructions take two cycles
// - met skip discards prefetch, dummy cycle
// - counter is fifteen bits wide
// - counter advances one after each fetch
// - jumps, calls, interrupts, reset load counter
// - reset clears counter to zero
// - first external or converter vector 0x004
// - second external or serial vector 0x008
// - first timer overflow vector 0x00C
// - second timer overflow vector 0x010
// - uart or alternative serial vector 0x014
// - multi-function interrupt vector 0x018
// - hold 1024 clocks after power-up or wake
`timescale 1ns/1ps
module psq_sequencer
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic wake_i,
  input wire psq_pkg::psq_op_type op_i,
  input wire logic op_valid_i,
  input wire logic skip_met_i,
  input wire logic [psq_pkg::INSN_ADDR_W-1:0] target_i,
  input wire logic bank_select_low_bit_i,
  input wire logic bank_select_high_bit_i,
  input wire logic [7:0] counter_low_byte_i,
  input wire logic [psq_pkg::PC_W-1:0] stack_top_i,
  input wire logic [psq_pkg::NUM_IRQ-1:0] irq_i,
  input wire logic [psq_pkg::WORD_W-1:0] prog_data_i,
  output logic [3:0] phase_o,
  output logic [psq_pkg::PC_W-1:0] prog_addr_o,
  output logic fetch_o,
  output logic [psq_pkg::WORD_W-1:0] insn_o,
  output logic insn_valid_o,
  output logic irq_ack_o,
  output logic [psq_pkg::PC_W-1:0] push_pc_o,
  output logic running_o
);
  import psq_pkg::*;

  psq_state_type state;
  psq_state_type next_state;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [3:0] next_phase_o;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [STARTUP_W-1:0] hold;
  logic [STARTUP_W-1:0] next_hold;
  logic [WORD_W-1:0] next_insn;
  logic next_insn_valid;
  logic next_fetch;
  logic next_ack;
  logic [PC_W-1:0] next_push;
  logic wake_s1;
  logic wake_s2;
  logic wake_s3;
  logic wake_rise;
  logic cycle_end;

  // priority vector selection, lowest index first
  function automatic logic [PC_W-1:0] irq_vector(input logic [NUM_IRQ-1:0] req);
    logic [PC_W-1:0] v;
    v = VEC_MULTI;
    if (req[0])
      v = VEC_EXT0;
    else if (req[1])
      v = VEC_EXT1;
    else if (req[2])
      v = VEC_TMR0;
    else if (req[3])
      v = VEC_TMR1;
    else if (req[4])
      v = VEC_UART;
    return v;
  endfunction

  assign wake_rise = wake_s2 & ~wake_s3;
  assign cycle_end = (phase == PHASE_LAST);

  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_hold = hold;
    next_pc = pc;
    next_insn = insn_o;
    next_insn_valid = 1'b0;
    next_fetch = 1'b0;
    next_ack = 1'b0;
    next_push = push_pc_o;
    next_phase = (state == PSQ_ST_HOLD) ? PHASE_FIRST : phase + 2'h1;
    next_phase_o = PHASE_ONE_HOT_ZERO << next_phase;
    case (state)
      PSQ_ST_HOLD:
      begin
        if (hold == STARTUP_ZERO)
          next_state = PSQ_ST_RUN;
        else
          next_hold = hold - 11'h001;
      end
      PSQ_ST_RUN, PSQ_ST_FLUSH:
      begin
        if (cycle_end)
        begin
          next_fetch = 1'b1;
          next_insn = prog_data_i;
          next_insn_valid = 1'b1;
          next_pc = pc + PC_STEP;
          next_state = PSQ_ST_RUN;
          if (|irq_i)
          begin
            next_ack = 1'b1;
            next_push = pc;
            next_pc = irq_vector(irq_i);
            next_state = PSQ_ST_FLUSH;
          end
          else if (op_valid_i && state == PSQ_ST_RUN)
          begin
            case (op_i)
              PSQ_OP_SKIP:
                if (skip_met_i)
                  next_state = PSQ_ST_FLUSH;
              PSQ_OP_JUMP, PSQ_OP_CALL:
              begin
                next_push = pc;
                next_pc = {bank_select_high_bit_i, bank_select_low_bit_i, target_i};
                next_state = PSQ_ST_FLUSH;
              end
              PSQ_OP_RET:
              begin
                next_pc = stack_top_i;
                next_state = PSQ_ST_FLUSH;
              end
              PSQ_OP_LOW:
              begin
                next_pc = {pc[PC_W-1:8], counter_low_byte_i};
                next_state = PSQ_ST_FLUSH;
              end
              default:
                next_state = PSQ_ST_RUN;
            endcase
          end
          if (next_state == PSQ_ST_FLUSH)
            next_insn_valid = 1'b0;
        end
      end
      default:
        next_state = PSQ_ST_HOLD;
    endcase
    if (wake_rise)
    begin
      next_state = PSQ_ST_HOLD;
      next_hold = STARTUP_HOLD_COUNT - 11'h001;
      next_phase = PHASE_FIRST;
      next_phase_o = PHASE_ONE_HOT_ZERO;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      state <= PSQ_ST_HOLD;
      phase <= PHASE_FIRST;
      phase_o <= PHASE_ONE_HOT_ZERO;
      hold <= STARTUP_HOLD_COUNT - 11'h001;
      pc <= VEC_RESET;
      insn_o <= '0;
      insn_valid_o <= 1'b0;
      fetch_o <= 1'b0;
      irq_ack_o <= 1'b0;
      push_pc_o <= VEC_RESET;
      running_o <= 1'b0;
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      phase_o <= next_phase_o;
      hold <= next_hold;
      pc <= next_pc;
      insn_o <= next_insn;
      insn_valid_o <= next_insn_valid;
      fetch_o <= next_fetch;
      irq_ack_o <= next_ack;
      push_pc_o <= next_push;
      running_o <= (next_state != PSQ_ST_HOLD);
      wake_s1 <= wake_i;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

  assign prog_addr_o = pc;
endmodule
